// ===== core/sgp_port.sv
module sgp_port (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// processor access
	input wire logic [19:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_bit_op,
	input wire logic [2:0] i_bit_sel,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// option byte strap
	input wire logic i_shared_pin_function_select,
	// pins
	input wire logic [4:0] i_first_pin,
	output logic [4:0] o_first_pin,
	output logic [4:0] o_first_pin_oe,
	output logic [4:0] o_first_pullup,
	input wire logic i_second_port_pin,
	output logic o_second_port_pin,
	output logic o_second_port_pin_oe,
	output logic o_second_pullup,
	input wire logic i_shared_reset_pin,
	output logic o_third_pullup,
	output logic o_pin_reset_req,
	input wire logic i_fourth_port_pin
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] fdir_q, fdir_d, sdir_q, sdir_d;
	logic [7:0] flat_q, flat_d, slat_q, slat_d;
	logic [7:0] fpu_q, fpu_d, spu_q, spu_d, tpu_q, tpu_d;
	logic [7:0] od_q, od_d, an_q, an_d;
	logic [7:0] rdata_q, rdata_d;
	logic [4:0] fo_q, fo_d, foe_q, foe_d, fpo_q, fpo_d;
	logic so_q, so_d, soe_q, soe_d, spo_q, spo_d, tpo_q, tpo_d;
	logic rreq_q, rreq_d, sel_q, sel_d, strap_done_q, strap_done_d;
	logic [7:0] pins;
	sgp_sync_if sync_bus ();

	// one synchroniser bit per pin, second port pin on bit 6
	assign sync_bus.raw = {i_fourth_port_pin, i_second_port_pin, i_shared_reset_pin,
		i_first_pin};
	sgp_sync u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.port(sync_bus)
	);
	assign pins = sync_bus.synced;

	// ------------------------------------------------------------
	// write merge for bit or byte access
	// ------------------------------------------------------------
	function automatic logic [7:0] wmerge(input logic [7:0] cur, input logic [7:0] mask,
		input logic [7:0] fixed);
		logic [7:0] v;
		v = cur;
		if (i_bit_op) begin
			v[i_bit_sel] = i_wdata[0];
		end else begin
			v = i_wdata;
		end
		wmerge = (v & mask) | fixed;
	endfunction : wmerge

	function automatic logic hit(input logic [19:0] a);
		hit = i_wr && (i_addr == a);
	endfunction : hit

	// ------------------------------------------------------------
	// register next state
	// ------------------------------------------------------------
	always_comb begin
		fdir_d = fdir_q;
		sdir_d = sdir_q;
		flat_d = flat_q;
		slat_d = slat_q;
		fpu_d = fpu_q;
		spu_d = spu_q;
		tpu_d = tpu_q;
		od_d = od_q;
		an_d = an_q;
		sel_d = sel_q;
		strap_done_d = 1'b1;
		if (!strap_done_q) begin
			sel_d = i_shared_pin_function_select;
		end
		if (hit(sgp_pkg::ADDR_FIRST_DIR)) begin
			fdir_d = wmerge(fdir_q, sgp_pkg::MASK_FIRST, ~sgp_pkg::MASK_FIRST);
		end
		if (hit(sgp_pkg::ADDR_SECOND_DIR)) begin
			sdir_d = wmerge(sdir_q, sgp_pkg::MASK_SECOND, ~sgp_pkg::MASK_SECOND);
		end
		if (hit(sgp_pkg::ADDR_FIRST_LATCH)) begin
			flat_d = wmerge(flat_q, sgp_pkg::MASK_FIRST, 8'h00);
		end
		if (hit(sgp_pkg::ADDR_SECOND_LATCH)) begin
			slat_d = wmerge(slat_q, sgp_pkg::MASK_SECOND, 8'h00);
		end
		if (hit(sgp_pkg::ADDR_FIRST_PU)) begin
			fpu_d = wmerge(fpu_q, sgp_pkg::MASK_FIRST, 8'h00);
		end
		if (hit(sgp_pkg::ADDR_SECOND_PU)) begin
			spu_d = wmerge(spu_q, sgp_pkg::MASK_SECOND, 8'h00);
		end
		if (hit(sgp_pkg::ADDR_THIRD_PU) && !sel_q) begin
			tpu_d = wmerge(tpu_q, sgp_pkg::MASK_THIRD, 8'h00);
		end
		if (hit(sgp_pkg::ADDR_OPEN_DRAIN)) begin
			od_d = wmerge(od_q, sgp_pkg::MASK_OPEN_DRAIN, 8'h00);
		end
		if (hit(sgp_pkg::ADDR_ANALOG_SEL)) begin
			an_d = wmerge(an_q, sgp_pkg::MASK_ANALOG, ~sgp_pkg::MASK_ANALOG);
		end
	end

	// ------------------------------------------------------------
	// pin drive, pull-ups and read data
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] fin;
		fin = (pins & ~(an_q & sgp_pkg::MASK_ANALOG)) & sgp_pkg::MASK_FIRST;
		for (int n = 0; n < 5; n++) begin
			// open-drain drives only a low
			if (n == 0 && od_q[0]) begin
				fo_d[n] = 1'b0;
				foe_d[n] = !fdir_q[n] && !flat_q[n];
			end else begin
				fo_d[n] = flat_q[n];
				foe_d[n] = !fdir_q[n];
			end
			fpo_d[n] = fdir_q[n] && fpu_q[n] && (n == 0 ? !od_q[0] : !an_q[n]);
		end
		so_d = slat_q[0];
		soe_d = !sdir_q[0];
		spo_d = sdir_q[0] && spu_q[0];
		tpo_d = tpu_q[sgp_pkg::THIRD_BIT] && !sel_q;
		rreq_d = sel_q && !pins[sgp_pkg::THIRD_BIT];
		rdata_d = 8'h00;
		if (i_rd) begin
			case (i_addr)
				sgp_pkg::ADDR_FIRST_LATCH: rdata_d = (fdir_q & fin) | (~fdir_q & flat_q
					& sgp_pkg::MASK_FIRST);
				sgp_pkg::ADDR_SECOND_LATCH: rdata_d = sdir_q[0] ? {7'h0, pins[6]}
					: slat_q & sgp_pkg::MASK_SECOND;
				sgp_pkg::ADDR_THIRD_DATA: rdata_d = sel_q ? sgp_pkg::MASK_THIRD
					: pins & sgp_pkg::MASK_THIRD;
				sgp_pkg::ADDR_FOURTH_DATA: rdata_d = pins & sgp_pkg::MASK_FOURTH;
				sgp_pkg::ADDR_FIRST_DIR: rdata_d = fdir_q;
				sgp_pkg::ADDR_SECOND_DIR: rdata_d = sdir_q;
				sgp_pkg::ADDR_FIRST_PU: rdata_d = fpu_q;
				sgp_pkg::ADDR_SECOND_PU: rdata_d = spu_q;
				sgp_pkg::ADDR_THIRD_PU: rdata_d = tpu_q;
				sgp_pkg::ADDR_OPEN_DRAIN: rdata_d = od_q;
				sgp_pkg::ADDR_ANALOG_SEL: rdata_d = an_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			fdir_q <= sgp_pkg::RST_DIR;
			sdir_q <= sgp_pkg::RST_DIR;
			flat_q <= sgp_pkg::RST_LATCH;
			slat_q <= sgp_pkg::RST_LATCH;
			fpu_q <= sgp_pkg::RST_FIRST_PU;
			spu_q <= sgp_pkg::RST_SECOND_PU;
			tpu_q <= sgp_pkg::RST_THIRD_PU;
			od_q <= sgp_pkg::RST_OPEN_DRAIN;
			an_q <= sgp_pkg::RST_ANALOG;
			rdata_q <= 8'h00;
			fo_q <= 5'h00;
			foe_q <= 5'h00;
			fpo_q <= 5'h00;
			so_q <= 1'b0;
			soe_q <= 1'b0;
			spo_q <= 1'b0;
			tpo_q <= 1'b0;
			rreq_q <= 1'b0;
			sel_q <= 1'b1;
			strap_done_q <= 1'b0;
		end else begin
			fdir_q <= fdir_d;
			sdir_q <= sdir_d;
			flat_q <= flat_d;
			slat_q <= slat_d;
			fpu_q <= fpu_d;
			spu_q <= spu_d;
			tpu_q <= tpu_d;
			od_q <= od_d;
			an_q <= an_d;
			rdata_q <= rdata_d;
			fo_q <= fo_d;
			foe_q <= foe_d;
			fpo_q <= fpo_d;
			so_q <= so_d;
			soe_q <= soe_d;
			spo_q <= spo_d;
			tpo_q <= tpo_d;
			rreq_q <= rreq_d;
			sel_q <= sel_d;
			strap_done_q <= strap_done_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_first_pin = fo_q;
	assign o_first_pin_oe = foe_q;
	assign o_first_pullup = fpo_q;
	assign o_second_port_pin = so_q;
	assign o_second_port_pin_oe = soe_q;
	assign o_second_pullup = spo_q;
	assign o_third_pullup = tpo_q;
	assign o_pin_reset_req = rreq_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_dir_reset_ones: assert property (@(posedge i_clock) i_rst |=>
		fdir_q == 8'hff && sdir_q == 8'hff) else $error("direction not reset to ones");
	a_first_fixed_bits: assert property (@(posedge i_clock) disable iff (i_rst)
		fdir_q[7:5] == 3'h7) else $error("first direction upper bits not one");
	a_second_fixed_bits: assert property (@(posedge i_clock) disable iff (i_rst)
		sdir_q[7:1] == 7'h7f) else $error("second direction upper bits not one");
	a_byte_write_dir: assert property (@(posedge i_clock) disable iff (i_rst)
		i_wr && !i_bit_op && i_addr == sgp_pkg::ADDR_FIRST_DIR |=>
		fdir_q[4:0] == $past(i_wdata[4:0])) else $error("direction byte write lost");
	a_bit_write_dir: assert property (@(posedge i_clock) disable iff (i_rst)
		i_wr && i_bit_op && i_bit_sel == 3'h0 && i_addr == sgp_pkg::ADDR_SECOND_DIR |=>
		sdir_q[0] == $past(i_wdata[0])) else $error("direction bit write lost");
	a_drive_follows_dir: assert property (@(posedge i_clock) disable iff (i_rst)
		!fdir_q[3] |=> o_first_pin_oe[3] && o_first_pin[3] == $past(flat_q[3]))
		else $error("output not driven from latch");
	a_open_drain_high: assert property (@(posedge i_clock) disable iff (i_rst)
		od_q[0] && flat_q[0] |=> !o_first_pin_oe[0]) else $error("open-drain drove high");
	a_pullup_gate: assert property (@(posedge i_clock) disable iff (i_rst)
		o_first_pullup[2] |-> $past(fdir_q[2]) && $past(!an_q[2]))
		else $error("pull-up in wrong mode");
	a_analog_reads_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		i_rd && i_addr == sgp_pkg::ADDR_FIRST_LATCH && fdir_q[1] && an_q[1] |=> !o_rdata[1])
		else $error("analog bit read nonzero");
	a_second_pullup: assert property (@(posedge i_clock) disable iff (i_rst)
		!sdir_q[0] |=> !o_second_pullup) else $error("second pull-up in output mode");
endmodule : sgp_port

// ===== core/sgp_pkg.sv
package sgp_pkg;
	// ------------------------------------------------------------
	// register addresses (20-bit processor space)
	// ------------------------------------------------------------
	localparam logic [19:0] ADDR_FIRST_LATCH = 20'hfff00;
	localparam logic [19:0] ADDR_SECOND_LATCH = 20'hfff04;
	localparam logic [19:0] ADDR_THIRD_DATA = 20'hfff0c;
	localparam logic [19:0] ADDR_FOURTH_DATA = 20'hfff0d;
	localparam logic [19:0] ADDR_FIRST_DIR = 20'hfff20;
	localparam logic [19:0] ADDR_SECOND_DIR = 20'hfff24;
	localparam logic [19:0] ADDR_FIRST_PU = 20'hf0030;
	localparam logic [19:0] ADDR_SECOND_PU = 20'hf0034;
	localparam logic [19:0] ADDR_THIRD_PU = 20'hf003c;
	localparam logic [19:0] ADDR_OPEN_DRAIN = 20'hf0050;
	localparam logic [19:0] ADDR_ANALOG_SEL = 20'hf0060;
	// ------------------------------------------------------------
	// implemented bit masks and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MASK_FIRST = 8'h1f;
	localparam logic [7:0] MASK_SECOND = 8'h01;
	localparam logic [7:0] MASK_THIRD = 8'h20;
	localparam logic [7:0] MASK_FOURTH = 8'h80;
	localparam logic [7:0] MASK_OPEN_DRAIN = 8'h01;
	localparam logic [7:0] MASK_ANALOG = 8'h1e;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_FIRST_PU = 8'h00;
	localparam logic [7:0] RST_SECOND_PU = 8'h01;
	localparam logic [7:0] RST_THIRD_PU = 8'h20;
	localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
	localparam logic [7:0] RST_ANALOG = 8'hff;
	localparam int THIRD_BIT = 5;
	localparam int FOURTH_BIT = 7;
endpackage : sgp_pkg

// ===== core/sgp_sync_if.sv
interface sgp_sync_if;
	logic [7:0] raw;
	logic [7:0] synced;
	modport src (output raw, input synced);
	modport snk (input raw, output synced);
endinterface : sgp_sync_if

// ===== core/sgp_sync.sv
module sgp_sync (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// pins
	sgp_sync_if.snk port
);
	logic [7:0] s1_q;
	logic [7:0] s1_d;
	logic [7:0] s2_q;
	logic [7:0] s2_d;

	always_comb begin
		s1_d = port.raw;
		s2_d = s1_q;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			// idle pins sit high, so no false low after reset
			s1_q <= 8'hff;
			s2_q <= 8'hff;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign port.synced = s2_q;
endmodule : sgp_sync

// ===== sim/sgp_board.sv
module sgp_board (
	// clock
	input wire logic i_clock,
	// device pin side
	input wire logic [6:0] i_drv,
	input wire logic [6:0] i_oe,
	input wire logic [6:0] i_pu,
	// board stimulus
	input wire logic [6:0] i_ext_en,
	input wire logic [6:0] i_ext_val,
	output logic [6:0] o_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flt_q = 1'b0;
	// an undriven pin without pull-up wanders
	always @(posedge i_clock) begin
		flt_q <= ~flt_q;
	end
	always_comb begin
		for (int b = 0; b < 7; b++) begin
			if (i_oe[b])
				o_lvl[b] = i_drv[b];
			else if (i_ext_en[b])
				o_lvl[b] = i_ext_val[b];
			else
				o_lvl[b] = i_pu[b] | flt_q;
		end
	end
endmodule : sgp_board

// ===== sim/tb_sgp_port.sv
module tb_sgp_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [19:0] i_addr = 20'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_bit_op = 1'b0;
	logic [2:0] i_bit_sel = 3'h0;
	logic [7:0] i_wdata = 8'h0;
	logic strap = 1'b1;
	logic i_fourth = 1'b0;
	logic [6:0] ext_en = 7'h7f;
	logic [6:0] ext_val = 7'h7f;
	logic [6:0] lvl;
	logic [7:0] o_rdata;
	logic [4:0] o_first_pin, o_first_pin_oe, o_first_pullup;
	logic o_second_port_pin, o_second_port_pin_oe, o_second_pullup, o_third_pullup, o_pin_reset_req;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	int n_fail = 0;
	int n_checks = 0;
	logic [4:0] p;
	always #5 i_clock = ~i_clock;
	sgp_port dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
		.i_bit_op(i_bit_op), .i_bit_sel(i_bit_sel), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_shared_pin_function_select(strap), .i_first_pin(lvl[4:0]), .o_first_pin(o_first_pin),
		.o_first_pin_oe(o_first_pin_oe), .o_first_pullup(o_first_pullup),
		.i_second_port_pin(lvl[5]), .o_second_port_pin(o_second_port_pin),
		.o_second_port_pin_oe(o_second_port_pin_oe), .o_second_pullup(o_second_pullup),
		.i_shared_reset_pin(lvl[6]), .o_third_pullup(o_third_pullup),
		.o_pin_reset_req(o_pin_reset_req), .i_fourth_port_pin(i_fourth));
	sgp_board board (.i_clock(i_clock), .i_drv({1'b0, o_second_port_pin, o_first_pin}),
		.i_oe({1'b0, o_second_port_pin_oe, o_first_pin_oe}),
		.i_pu({o_third_pullup, o_second_pullup, o_first_pullup}),
		.i_ext_en(ext_en), .i_ext_val(ext_val), .o_lvl(lvl));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : cyc
	task automatic acc(input logic [19:0] a, input logic w, input logic bo, input logic [2:0] bs,
		input logic [7:0] d);
		@(posedge i_clock);
		#1;
		i_addr = a;
		i_wr = w;
		i_rd = ~w;
		i_bit_op = bo;
		i_bit_sel = bs;
		i_wdata = d;
		cyc(1);
		i_wr = 1'b0;
		i_rd = 1'b0;
	endtask : acc
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		acc(a, 1'b1, 1'b0, 3'h0, d);
		cyc(2);
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(a, 1'b0, 1'b0, 3'h0, 8'h0);
	endtask : rd
	task automatic do_reset(input logic s);
		i_rst = 1'b1;
		strap = s;
		ext_val[6] = 1'b1;
		cyc(5);
		i_rst = 1'b0;
		cyc(2);
	endtask : do_reset
	task automatic close_out();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// read data is valid in the cycle after the read edge
	always @(posedge i_clock) rd_seen <= i_rd;
	always @(negedge i_clock) begin
		if (rd_seen) begin
			if (exp_q.size() == 0)
				chk("stray read", 8'h0, 8'hff);
			else
				chk("o_rdata", exp_q.pop_front(), o_rdata);
		end
	end
	initial begin
		#100us;
		n_fail++;
		close_out();
	end
	initial begin
		void'($urandom(8601));
		do_reset(1'b1);
		chk("first oe", 8'h0, {3'h0, o_first_pin_oe});
		chk("second pullup", 8'h1, {7'h0, o_second_pullup});
		rd(sgp_pkg::ADDR_FIRST_DIR, 8'hff);
		rd(sgp_pkg::ADDR_SECOND_DIR, 8'hff);
		rd(20'hfff30, 8'h00);
		rd(sgp_pkg::ADDR_SECOND_LATCH, 8'h01);
		wr(sgp_pkg::ADDR_FIRST_DIR, 8'he0);
		rd(sgp_pkg::ADDR_FIRST_DIR, 8'he0);
		chk("first oe", 8'h1f, {3'h0, o_first_pin_oe});
		for (int b = 0; b < 5; b++) begin
			acc(sgp_pkg::ADDR_FIRST_DIR, 1'b1, 1'b1, b[2:0], 8'h01);
			cyc(2);
			chk("bit oe", 8'(8'h1f << (b + 1)) & 8'h1f, {3'h0, o_first_pin_oe});
		end
		wr(sgp_pkg::ADDR_FIRST_DIR, 8'he0);
		p = 5'($urandom);
		wr(sgp_pkg::ADDR_FIRST_LATCH, {3'h0, p});
		chk("first pin", {3'h0, p}, {3'h0, o_first_pin});
		rd(sgp_pkg::ADDR_FIRST_LATCH, {3'h0, p});
		p = 5'($urandom);
		ext_val[4:0] = p;
		wr(sgp_pkg::ADDR_FIRST_DIR, 8'hff);
		cyc(3);
		rd(sgp_pkg::ADDR_FIRST_LATCH, {7'h0, p[0]});
		wr(sgp_pkg::ADDR_ANALOG_SEL, 8'he1);
		rd(sgp_pkg::ADDR_FIRST_LATCH, {3'h0, p});
		ext_en[4:0] = 5'h0;
		wr(sgp_pkg::ADDR_FIRST_PU, 8'h1f);
		chk("first pullup", 8'h1f, {3'h0, o_first_pullup});
		wr(sgp_pkg::ADDR_OPEN_DRAIN, 8'h01);
		chk("first pullup", 8'h1e, {3'h0, o_first_pullup});
		wr(sgp_pkg::ADDR_FIRST_DIR, 8'he0);
		chk("first pullup", 8'h00, {3'h0, o_first_pullup});
		wr(sgp_pkg::ADDR_FIRST_LATCH, 8'h00);
		chk("drain oe", 8'h1f, {3'h0, o_first_pin_oe});
		chk("drain pin", 8'h00, {7'h0, o_first_pin[0]});
		wr(sgp_pkg::ADDR_FIRST_LATCH, 8'h01);
		chk("drain oe", 8'h1e, {3'h0, o_first_pin_oe});
		rd(sgp_pkg::ADDR_FIRST_LATCH, 8'h01);
		wr(sgp_pkg::ADDR_SECOND_LATCH, 8'h01);
		acc(sgp_pkg::ADDR_SECOND_DIR, 1'b1, 1'b1, 3'h0, 8'h00);
		cyc(2);
		rd(sgp_pkg::ADDR_SECOND_DIR, 8'hfe);
		chk("second drive", 8'h3, {6'h0, o_second_port_pin_oe, o_second_port_pin});
		chk("second pullup", 8'h0, {7'h0, o_second_pullup});
		wr(sgp_pkg::ADDR_THIRD_PU, 8'h20);
		chk("third pullup", 8'h0, {7'h0, o_third_pullup});
		ext_val[6] = 1'b0;
		cyc(4);
		chk("reset req", 8'h1, {7'h0, o_pin_reset_req});
		rd(sgp_pkg::ADDR_THIRD_DATA, 8'h20);
		for (int v = 0; v < 2; v++) begin
			i_fourth = v[0];
			cyc(4);
			rd(sgp_pkg::ADDR_FOURTH_DATA, {v[0], 7'h0});
		end
		do_reset(1'b0);
		chk("third pullup", 8'h1, {7'h0, o_third_pullup});
		ext_val[6] = 1'b0;
		cyc(4);
		chk("reset req", 8'h0, {7'h0, o_pin_reset_req});
		rd(sgp_pkg::ADDR_THIRD_DATA, 8'h00);
		wr(sgp_pkg::ADDR_THIRD_PU, 8'h00);
		chk("third pullup", 8'h0, {7'h0, o_third_pullup});
		cyc(2);
		close_out();
	end
endmodule : tb_sgp_port
